// >>> rtl/irq_router_regs.vh
// Register map, field layout and reset values of the system interrupt router.
// Assumes word indices on a plain strobe port; included by its bare name.
`ifndef IRQ_ROUTER_REGS_VH
`define IRQ_ROUTER_REGS_VH

// Register indices (address port)
`define ADDR_ASSIGN_REG_0 4'h0
`define ADDR_ASSIGN_REG_1 4'h1
`define ADDR_ASSIGN_REG_2 4'h2
`define ADDR_ASSIGN_REG_3 4'h3
`define ADDR_SOURCE_MASK 4'h4
`define ADDR_SOURCE_STATUS 4'h5
`define ADDR_WAKEUP_ENABLE 4'h6
`define ADDR_IRQ_PENDING 4'h7
`define ADDR_IRQ_ENABLE 4'h8

// Assignment field layout: four bits per source, eight sources per register
`define ASSIGN_FIELD_W 4
`define ASSIGN_PER_REG 8

// Default core interrupt IDs at reset
`define ASSIGN_RESET_0 32'h00000000
`define ASSIGN_RESET_1 32'h11000000
`define ASSIGN_RESET_2 32'h33332222
`define ASSIGN_RESET_3 32'h00000033
`define MASK_RESET 32'h00000000
`define WAKEUP_RESET 32'h00000000

// Level numbering
`define CORE_TIMER_LEVEL 6
`define GP_LEVEL_FIRST 7
`define GP_LEVEL_LAST 15

// Reserved source IDs
`define RESERVED_ID_A 10
`define RESERVED_ID_B 11

// Internal event bits of the pending/enable pair
`define EVT_WAKE_BIT 0
`define EVT_WRITE_BIT 1

`endif

// >>> rtl/system_irq_router.v
// System interrupt router: maps peripheral sources onto core general-purpose levels.
// Assumes synchronous source levels and a single-cycle register strobe port.
//
// Notes on behaviour
// - Core timer is level 6; levels 7..15 follow, lower number higher priority.
// - After reset sources 0..7 route to level 7 (ID 0).
// - After reset sources 8..13 route to level 7 (ID 0).
// - After reset sources 14 and 15 route to level 8 (ID 1).
// - After reset sources 16..19 route to level 9 (ID 2).
// - After reset sources 20..25 route to level 10 (ID 3).
// - Four assignment registers, eight sources each; register 3 holds 24..25.
// - Sources 10 and 11 are reserved, inputs tied inactive, default level 7.
// - Assignment ID selects level seven plus ID.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "irq_router_regs.vh"

module system_irq_router #(
  parameter NUM_SOURCES = 26,
  parameter ADDR_W = 4
) (
  input wire core_clk,
  input wire resetn,
  input wire [NUM_SOURCES-1:0] sourceReq,
  input wire [ADDR_W-1:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata,
  output reg [8:0] gpLevelReq,
  output reg wakeupReq,
  output reg irqOut
);

  localparam NUM_LEVELS = `GP_LEVEL_LAST - `GP_LEVEL_FIRST + 1;
  localparam FW = `ASSIGN_FIELD_W;

  reg [31:0] assignReg0_q;
  reg [31:0] assignReg1_q;
  reg [31:0] assignReg2_q;
  reg [31:0] assignReg3_q;
  reg [NUM_SOURCES-1:0] sourceMask_q;
  reg [NUM_SOURCES-1:0] sourceStatus_q;
  reg [NUM_SOURCES-1:0] wakeupEnable_q;
  reg [1:0] irqPending_q;
  reg [1:0] irqEnable_q;
  reg wakeupPrev_q;

  wire [127:0] assignAll;
  wire [NUM_SOURCES-1:0] liveReq;
  wire [NUM_SOURCES-1:0] unmaskedReq;
  wire [NUM_LEVELS-1:0] levelHit [0:NUM_SOURCES-1];
  reg [NUM_LEVELS-1:0] levelReq_d;
  reg [31:0] rdata_d;
  reg [1:0] pending_d;
  wire wakeup_d;
  wire assignWrite;
  integer s;

  // Register 3 field space beyond ID 25 stays unused
  assign assignAll = {assignReg3_q, assignReg2_q, assignReg1_q, assignReg0_q};

  genvar g;
  generate
    for (g = 0; g < NUM_SOURCES; g = g + 1) begin : gSrc
      wire [FW-1:0] coreId;
      if (g == `RESERVED_ID_A || g == `RESERVED_ID_B) begin : gRsv
        assign liveReq[g] = 1'b0;
      end else begin : gLive
        assign liveReq[g] = sourceReq[g];
      end
      assign coreId = assignAll[g*FW +: FW];
      // ID n picks level 7+n; IDs past the top level select nothing
      assign levelHit[g] = (coreId < NUM_LEVELS) ?
        ({{(NUM_LEVELS-1){1'b0}}, 1'b1} << coreId) : {NUM_LEVELS{1'b0}};
    end
  endgenerate

  // Mask bit set means the source is enabled
  assign unmaskedReq = liveReq & sourceMask_q;

  always @* begin
    levelReq_d = {NUM_LEVELS{1'b0}};
    for (s = 0; s < NUM_SOURCES; s = s + 1) begin
      if (unmaskedReq[s]) begin
        levelReq_d = levelReq_d | levelHit[s];
      end
    end
  end

  assign wakeup_d = |(liveReq & wakeupEnable_q);
  assign assignWrite = regWrite && (regAddr <= `ADDR_ASSIGN_REG_3);

  // Hardware set wins over a write-one clear in the same cycle
  always @* begin
    pending_d = irqPending_q;
    if (regWrite && regAddr == `ADDR_IRQ_PENDING) begin
      pending_d = pending_d & ~regWdata[1:0];
    end
    if (wakeup_d && !wakeupPrev_q) begin
      pending_d[`EVT_WAKE_BIT] = 1'b1;
    end
    if (assignWrite) begin
      pending_d[`EVT_WRITE_BIT] = 1'b1;
    end
  end

  always @* begin
    rdata_d = 32'h00000000;
    case (regAddr)
      `ADDR_ASSIGN_REG_0: rdata_d = assignReg0_q;
      `ADDR_ASSIGN_REG_1: rdata_d = assignReg1_q;
      `ADDR_ASSIGN_REG_2: rdata_d = assignReg2_q;
      `ADDR_ASSIGN_REG_3: rdata_d = assignReg3_q;
      `ADDR_SOURCE_MASK: rdata_d[NUM_SOURCES-1:0] = sourceMask_q;
      `ADDR_SOURCE_STATUS: rdata_d[NUM_SOURCES-1:0] = sourceStatus_q;
      `ADDR_WAKEUP_ENABLE: rdata_d[NUM_SOURCES-1:0] = wakeupEnable_q;
      `ADDR_IRQ_PENDING: rdata_d[1:0] = irqPending_q;
      `ADDR_IRQ_ENABLE: rdata_d[1:0] = irqEnable_q;
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      assignReg0_q <= `ASSIGN_RESET_0;
      assignReg1_q <= `ASSIGN_RESET_1;
      assignReg2_q <= `ASSIGN_RESET_2;
      assignReg3_q <= `ASSIGN_RESET_3;
      sourceMask_q <= {NUM_SOURCES{1'b0}};
      wakeupEnable_q <= {NUM_SOURCES{1'b0}};
      sourceStatus_q <= {NUM_SOURCES{1'b0}};
      irqPending_q <= 2'h0;
      irqEnable_q <= 2'h0;
      wakeupPrev_q <= 1'b0;
      regRdata <= 32'h00000000;
      gpLevelReq <= 9'h000;
      wakeupReq <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      if (regWrite) begin
        // Only ID bits beyond register 3's two fields are kept at zero
        case (regAddr)
          `ADDR_ASSIGN_REG_0: assignReg0_q <= regWdata;
          `ADDR_ASSIGN_REG_1: assignReg1_q <= regWdata;
          `ADDR_ASSIGN_REG_2: assignReg2_q <= regWdata;
          `ADDR_ASSIGN_REG_3: assignReg3_q <= {24'h000000, regWdata[7:0]};
          `ADDR_SOURCE_MASK: sourceMask_q <= regWdata[NUM_SOURCES-1:0];
          `ADDR_WAKEUP_ENABLE: wakeupEnable_q <= regWdata[NUM_SOURCES-1:0];
          `ADDR_IRQ_ENABLE: irqEnable_q <= regWdata[1:0];
          default: ;
        endcase
      end
      sourceStatus_q <= liveReq;
      irqPending_q <= pending_d;
      wakeupPrev_q <= wakeup_d;
      regRdata <= regRead ? rdata_d : 32'h00000000;
      gpLevelReq <= levelReq_d;
      wakeupReq <= wakeup_d;
      irqOut <= |(pending_d & irqEnable_q);
    end
  end

endmodule

// >>> tb/core_event_ctrl_model.sv
// Core event controller model: serves the most urgent raised level.
// Fed by the router's level lines; 0 means idle.
`timescale 1ns/1ps
module core_event_ctrl_model (input wire [8:0] gpLevelReq, output reg [3:0] servLevel);
  integer k;
  always @* begin
    servLevel = 4'h0;
    for (k = 8; k >= 0; k--) if (gpLevelReq[k]) servLevel = 4'h7 + k[3:0];
  end
endmodule

// >>> tb/system_irq_router_sva.sv
// Port checker for the interrupt router.
// Bound into system_irq_router; sees its ports only.
`timescale 1ns/1ps
module system_irq_router_sva #(parameter NUM_SOURCES = 26, parameter ADDR_W = 4) (
  input wire core_clk, input wire resetn, input wire [NUM_SOURCES-1:0] sourceReq,
  input wire [ADDR_W-1:0] regAddr, input wire regWrite, input wire regRead,
  input wire [31:0] regRdata, input wire [8:0] gpLevelReq, input wire wakeupReq);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_lv; gpLevelReq != 9'h0 |-> |$past(sourceReq); endproperty
  a_lv: assert property (p_lv) else $error("level without source");
  property p_hd; ($stable(sourceReq) && !regWrite) [*3] |-> $stable(gpLevelReq); endproperty
  a_hd: assert property (p_hd) else $error("level moved");
  property p_wk; wakeupReq |-> |$past(sourceReq); endproperty
  a_wk: assert property (p_wk) else $error("stray wakeup");
  property p_rs; $past(sourceReq & ~26'hc00) == 0 |-> !wakeupReq && gpLevelReq == 9'h0; endproperty
  a_rs: assert property (p_rs) else $error("reserved source seen");
  property p_st; regRead && regAddr == 4'h5 |=> regRdata[11:10] == 2'h0; endproperty
  a_st: assert property (p_st) else $error("reserved status bit");
  property p_rz; !$past(regRead) |-> regRdata == 32'h0; endproperty
  a_rz: assert property (p_rz) else $error("stray read data");
  property p_um; regRead && regAddr > 4'h8 |=> regRdata == 32'h0; endproperty
  a_um: assert property (p_um) else $error("unmapped read");
  property p_up; regRead && regAddr inside {4'h4, 4'h5, 4'h6} |=> regRdata[31:26] == 6'h0; endproperty
  a_up: assert property (p_up) else $error("upper bits set");
  c_lv: cover property (gpLevelReq[6]);
  c_wk: cover property (wakeupReq);
  c_rd: cover property (regRead ##1 regRdata != 32'h0);
endmodule
bind system_irq_router system_irq_router_sva #(.NUM_SOURCES(NUM_SOURCES), .ADDR_W(ADDR_W)) u_sva (.*);

// >>> tb/system_irq_router_tb_top.sv
// Bench: strobe-port tasks and routing tests for the router.
// Drives sources and registers; the controller model watches levels.
`timescale 1ns/1ps
module system_irq_router_tb_top;
  reg core_clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  reg [25:0] sourceReq = 26'h0;
  reg [3:0] regAddr = 4'h0;
  reg [31:0] regWdata = 32'h0;
  wire [31:0] regRdata;
  wire [8:0] gpLevelReq;
  wire [3:0] servLevel;
  wire wakeupReq, irqOut;
  integer num_errors = 0, n_tests = 0, cyc = 0, n, id;
  always #25 core_clk = ~core_clk;
  system_irq_router system_irq_router_inst (.*);
  core_event_ctrl_model core_event_ctrl_model_inst (.*);
  task chk(input [31:0] g, input [31:0] e);
    n_tests++;
    if (g !== e) num_errors++;
    if (g !== e) $display("BAD %0t got %h exp %h", $time, g, e);
  endtask
  task acc(input w, input [3:0] a, input [31:0] d);
    @(posedge core_clk);
    {regWrite, regRead, regAddr, regWdata} <= {w, !w, a, d};
    @(posedge core_clk);
    {regWrite, regRead} <= 2'h0;
    #1 if (!w) chk(regRdata, d);
  endtask
  task src(input [25:0] v);
    @(posedge core_clk) sourceReq <= v;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task give_verdict;
    if (cyc >= 3000) num_errors++;
    $display("checks %0d bad %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk) if (++cyc == 3000) give_verdict;
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    acc(0, 4'h1, 32'h11000000);
    acc(0, 4'h3, 32'h33);
    acc(0, 4'h9, 0);
    acc(1, 4'h8, 2);
    acc(1, 4'h4, 32'h3ffffff);
    for (n = 0; n < 26; n++) begin
      id = (n < 14) ? 1 : (n < 16) ? 2 : (n < 20) ? 4 : 8;
      if (n == 10 || n == 11) id = 0;
      src(1 << n);
      chk(gpLevelReq, id);
      acc(0, 4'h5, id ? 1 << n : 0);
    end
    $display("default routing test done");
    acc(1, 4'h0, 6);
    src(1);
    chk({irqOut, servLevel}, 29);
    $display("reassign test done");
    acc(1, 4'h7, 2);
    acc(1, 4'h4, 0);
    src(1 << 20);
    chk({irqOut, gpLevelReq}, 0);
    acc(0, 4'h5, 1 << 20);
    $display("mask test done");
    acc(1, 4'h6, 32'h100c00);
    src(1 << 20);
    chk(wakeupReq, 1);
    $display("wakeup test done");
    give_verdict;
  end
endmodule
